// File: design/lsc_pkg.sv
// Constants, encodings and state type for the line status and command unit
package lsc_pkg;
  // Frame bytes and answers
  localparam logic [7:0] HDR_BYTE    = 8'hff;
  localparam logic [7:0] ESC_BYTE    = 8'hfe;
  localparam logic [7:0] ESC_SET     = 8'h80;
  localparam logic [7:0] ACK_BYTE    = 8'h06;
  localparam logic [7:0] NACK_BYTE   = 8'h15;
  // Register addresses
  localparam logic [7:0] ADDR_STATUS = 8'hc6;
  localparam logic [7:0] ADDR_OP     = 8'hc7;
  // Operation values
  localparam logic [7:0] OP_SEND     = 8'h01;
  localparam logic [7:0] OP_GET_HDR  = 8'h02;
  localparam logic [7:0] OP_GET_PAY  = 8'h03;
  localparam logic [7:0] OP_GET_ALL  = 8'h04;
  localparam logic [7:0] OP_DROP_RX  = 8'h05;
  localparam logic [7:0] OP_FLUSH_OB = 8'h06;
  localparam logic [7:0] OP_FLUSH_IB = 8'h07;
  localparam logic [7:0] OP_JOIN     = 8'h10;
  localparam logic [7:0] OP_KEY_WR   = 8'h11;
  localparam logic [7:0] OP_KEY_ERA  = 8'h12;
  localparam logic [7:0] OP_KEY_RST  = 8'h13;
  localparam logic [7:0] OP_FACTORY  = 8'h20;
  localparam logic [7:0] FACT_KEY1   = 8'haa;
  localparam logic [7:0] FACT_KEY2   = 8'hbb;
  // Join subcommands and key selectors
  localparam logic [7:0] JOIN_STOP   = 8'h00;
  localparam logic [7:0] JOIN_ADMIN  = 8'h01;
  localparam logic [7:0] JOIN_NODE   = 8'h02;
  localparam logic [7:0] SEL_RUNTIME = 8'h01;
  localparam logic [7:0] SEL_STORED  = 8'h02;
  // Sizes
  localparam int         KEY_BYTES   = 16;
  localparam int         BODY_LEN    = 19;
  localparam int         FIFO_DEPTH  = 8;
  localparam int         FIFO_WIDTH  = 8;
  localparam logic [4:0] MSG_LEN     = 5'd23;
  localparam logic [4:0] READ_LEN    = 5'd3;
  localparam logic [8*23-1:0] RESET_MSG =
    {8'h0d, 8'h0a, "Configuration Reset", 8'h0d, 8'h0a};
  // Parser states
  typedef enum logic [4:0] {
    ST_HDR  = 5'h01,
    ST_SIZE = 5'h02,
    ST_BODY = 5'h04,
    ST_EXEC = 5'h08,
    ST_RESP = 5'h10
  } lsc_state_t;
endpackage

// File: design/lsc_top.sv
// Line status byte, command decoder, key store and answer FIFO
// Functional notes
// - Status read returns six indicator lines in bits 0..5.
// - Status read frame uses escaped address; answer is ACK, address, status.
// - Operation register is write-only, reached at escaped address 0x47.
// - Decode send, three gets, three clears, join, key ops, factory reset.
// - Send with explicit mode off flushes waiting data like a timeout.
// - Send with explicit mode on marks end of a queued packet.
// - Get-header delivers then discards header; repeat skips unread data.
// - Gets answer NACK when packet mode off or previous get unfinished.
// - Get-payload delivers then discards data, dropping an unread header.
// - Get-whole delivers header then data, then removes the packet.
// - Drop-packet removes next packet and ends pending get; else drops all.
// - Flush-outbound aborts transmission and empties waiting data.
// - Flush-inbound discards undelivered bytes and clears receive-waiting flag.
// - Join subcommands: 0 halts, 1 becomes administrator, 2 joins peer.
// - Push-button join requests ignored until serial join finishes.
// - During join, writes refused except halt; halt completes before ACK.
// - Role latched from key-receive at start; success copies addresses.
// - Key write: selector then 16 bytes; runtime key loads at power-up.
// - An all-zero key means no key present.
// - Key erase zeroes runtime or stored key per selector.
// - Key restore copies stored key into runtime key.
// - Factory frame restores defaults, queues reset message, resets once its last byte is queued.
// - Receive-waiting flag high while undelivered inbound bytes remain.
`timescale 1ns/100ps

module lsc_fifo #(
  parameter int W = 8,
  parameter int D = 8
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         rst_n,
  // Fill side
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  // Drain side
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  localparam int AW = $clog2(D);
  logic [W-1:0] mem [D];
  logic [AW:0]  wr_ptr;
  logic [AW:0]  rd_ptr;

  // Full and empty from pointer wrap bit
  assign in_ready  = (wr_ptr != {~rd_ptr[AW], rd_ptr[AW-1:0]});
  assign out_valid = (wr_ptr != rd_ptr);
  assign out_data  = mem[rd_ptr[AW-1:0]];

  // Pointers and storage
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      if (in_valid && in_ready) begin
        mem[wr_ptr[AW-1:0]] <= in_data;
        wr_ptr              <= wr_ptr + 1'b1;
      end
      if (out_valid && out_ready) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
    end
  end
endmodule

module lsc_top (
  // Clock and reset
  input  wire logic         CLK,
  input  wire logic         RST_N,
  // Command bytes from the UART
  input  wire logic         RX_VALID,
  input  wire logic [7:0]   RX_DATA,
  output logic              RX_READY,
  // Answer bytes to the UART
  output logic              TX_VALID,
  output logic [7:0]        TX_DATA,
  input  wire logic         TX_READY,
  // Indicator lines
  input  wire logic         FAULT_EVENT_LINE,
  input  wire logic         TRANSMIT_AMP_ON,
  input  wire logic         RECEIVE_AMP_ON,
  input  wire logic         INBOUND_NEAR_FULL,
  input  wire logic         RF_ACTIVITY_INDICATOR,
  input  wire logic         UART_BUFFER_EMPTY,
  // Configuration
  input  wire logic         EXPLICIT_TX_PACKET_MODE,
  input  wire logic         RECEIVED_PACKET_MODE,
  input  wire logic         KEY_RECEIVE_PERMIT,
  // Events from packet buffers and join logic
  input  wire logic         RX_XFER_DONE,
  input  wire logic         RX_UNDELIVERED,
  input  wire logic         JOIN_DONE,
  input  wire logic         JOIN_OK,
  input  wire logic         PB_JOIN_REQ,
  // Operation strobes
  output logic              SEND_FLUSH,
  output logic              SEND_MARK,
  output logic              GET_HEADER,
  output logic              GET_PAYLOAD,
  output logic              GET_WHOLE,
  output logic              DROP_RX_PACKET,
  output logic              DROP_RX_ALL,
  output logic              FLUSH_OUTBOUND,
  output logic              FLUSH_INBOUND,
  output logic              JOIN_HALT,
  output logic              JOIN_START,
  output logic              KEY_RCV_CLEAR,
  output logic              COPY_NV_ADDR,
  output logic              PB_JOIN_GO,
  output logic              NV_DEFAULTS,
  output logic              SELF_RESET,
  // Levels
  output logic              JOIN_ACTIVE,
  output logic              JOIN_AS_ADMIN,
  output logic              RECEIVE_WAITING_FLAG,
  output logic              RUNTIME_KEY_PRESENT,
  output logic              STORED_KEY_PRESENT,
  output logic [127:0]      RUNTIME_KEY
);
  lsc_pkg::lsc_state_t state;
  lsc_pkg::lsc_state_t next_state;
  logic [7:0]  body [lsc_pkg::BODY_LEN];
  logic [7:0]  runtime_key [lsc_pkg::KEY_BYTES];
  logic [7:0]  stored_key [lsc_pkg::KEY_BYTES];
  logic [7:0]  output_line_status;
  logic [7:0]  remain;
  logic [4:0]  bcnt;
  logic [1:0]  esc_cnt;
  logic        is_read;
  logic        rx_take;
  logic        retr_busy;
  logic        load_pend;
  logic [7:0]  resp_code;
  logic [4:0]  resp_len;
  logic [4:0]  resp_idx;
  logic        resp_msg;
  logic        push_ok;
  logic        push_ok_raw;
  logic [7:0]  push_data;
  logic        fifo_valid;
  logic [7:0]  fifo_data;
  logic        fifo_take;
  logic [7:0]  op;
  logic [7:0]  arg;
  logic        wr_frame;
  logic        is_halt;
  logic        refused;
  logic        get_op;

  // True when any byte of a key is non-zero
  function automatic logic key_nonzero(input logic [7:0] k [lsc_pkg::KEY_BYTES]);
    logic nz;
    nz = 1'b0;
    for (int i = 0; i < lsc_pkg::KEY_BYTES; i++) nz = nz | (|k[i]);
    return nz;
  endfunction

  // Answer byte at a given position
  function automatic logic [7:0] resp_byte(input logic msg, input logic [4:0] idx,
                                           input logic [7:0] code, input logic [7:0] st);
    if (msg) return lsc_pkg::RESET_MSG[8*(22-int'(idx)) +: 8];
    else if (idx == 5'd0) return code;
    else if (idx == 5'd1) return lsc_pkg::ADDR_STATUS;
    else return st;
  endfunction

  assign rx_take  = RX_VALID && RX_READY;
  assign op       = body[1];
  assign arg      = body[2];
  assign wr_frame = !is_read && body[0] == lsc_pkg::ADDR_OP;
  assign is_halt  = op == lsc_pkg::OP_JOIN && arg == lsc_pkg::JOIN_STOP;
  assign refused  = JOIN_ACTIVE && !is_halt;
  assign get_op   = op == lsc_pkg::OP_GET_HDR || op == lsc_pkg::OP_GET_PAY
                    || op == lsc_pkg::OP_GET_ALL;
  assign push_data = resp_byte(resp_msg, resp_idx, resp_code, output_line_status);
  assign fifo_take = !TX_VALID || TX_READY;

  // Frame parser next state
  always_comb begin
    next_state = state;
    case (state)
      lsc_pkg::ST_HDR: begin
        if (rx_take && RX_DATA == lsc_pkg::HDR_BYTE) next_state = lsc_pkg::ST_SIZE;
      end
      lsc_pkg::ST_SIZE: begin
        if (rx_take) next_state = (RX_DATA == 8'h00) ? lsc_pkg::ST_HDR : lsc_pkg::ST_BODY;
      end
      lsc_pkg::ST_BODY: begin
        if (rx_take && remain == 8'h01) next_state = lsc_pkg::ST_EXEC;
      end
      lsc_pkg::ST_EXEC: begin
        next_state = lsc_pkg::ST_RESP;
      end
      lsc_pkg::ST_RESP: begin
        if (push_ok && resp_idx == resp_len - 5'd1) next_state = lsc_pkg::ST_HDR;
      end
      default: next_state = lsc_pkg::ST_HDR;
    endcase
  end

  // Parser state and byte ready
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      state    <= lsc_pkg::ST_HDR;
      RX_READY <= 1'b0;
    end else begin
      state    <= next_state;
      RX_READY <= next_state == lsc_pkg::ST_HDR || next_state == lsc_pkg::ST_SIZE
                  || next_state == lsc_pkg::ST_BODY;
    end
  end

  // Body collection with escape decoding
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      remain  <= 8'h00;
      bcnt    <= 5'd0;
      esc_cnt <= 2'd0;
      is_read <= 1'b0;
      for (int i = 0; i < lsc_pkg::BODY_LEN; i++) body[i] <= 8'h00;
    end else if (rx_take && state == lsc_pkg::ST_SIZE) begin
      remain  <= RX_DATA;
      bcnt    <= 5'd0;
      esc_cnt <= 2'd0;
      is_read <= 1'b0;
    end else if (rx_take && state == lsc_pkg::ST_BODY) begin
      remain <= remain - 8'h01;
      if (RX_DATA == lsc_pkg::ESC_BYTE) begin
        if (esc_cnt != 2'd3) esc_cnt <= esc_cnt + 2'd1;
      end else begin
        esc_cnt <= 2'd0;
        if (bcnt == 5'd0) is_read <= esc_cnt >= 2'd2;
        if (int'(bcnt) < lsc_pkg::BODY_LEN) begin
          body[bcnt] <= (esc_cnt != 2'd0) ? (RX_DATA | lsc_pkg::ESC_SET) : RX_DATA;
          bcnt       <= bcnt + 5'd1;
        end
      end
    end
  end

  // Status byte mirrors indicator lines, reserved bits zero
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      output_line_status <= 8'h00;
    end else begin
      output_line_status <= {2'b00, UART_BUFFER_EMPTY, RF_ACTIVITY_INDICATOR,
                             INBOUND_NEAR_FULL, RECEIVE_AMP_ON, TRANSMIT_AMP_ON,
                             FAULT_EVENT_LINE};
    end
  end

  // Answer selection at execute, byte push during answer
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      resp_code <= lsc_pkg::ACK_BYTE;
      resp_len  <= 5'd1;
      resp_idx  <= 5'd0;
      resp_msg  <= 1'b0;
    end else if (state == lsc_pkg::ST_EXEC) begin
      resp_idx  <= 5'd0;
      resp_msg  <= 1'b0;
      resp_len  <= 5'd1;
      resp_code <= lsc_pkg::NACK_BYTE;
      if (is_read && body[0] == lsc_pkg::ADDR_STATUS) begin
        resp_code <= lsc_pkg::ACK_BYTE;
        resp_len  <= lsc_pkg::READ_LEN;
      end else if (wr_frame && !refused) begin
        if (op == lsc_pkg::OP_FACTORY) begin
          if (arg == lsc_pkg::FACT_KEY1 && body[3] == lsc_pkg::FACT_KEY2) begin
            resp_msg <= 1'b1;
            resp_len <= lsc_pkg::MSG_LEN;
          end
        end else if (get_op) begin
          if (RECEIVED_PACKET_MODE && !retr_busy) resp_code <= lsc_pkg::ACK_BYTE;
        end else if (op != 8'h00 && op <= lsc_pkg::OP_FLUSH_IB) begin
          resp_code <= lsc_pkg::ACK_BYTE;
        end else if (op >= lsc_pkg::OP_JOIN && op <= lsc_pkg::OP_KEY_RST) begin
          resp_code <= lsc_pkg::ACK_BYTE;
        end
      end
    end else if (push_ok) begin
      resp_idx <= resp_idx + 5'd1;
    end
  end

  // Answer FIFO and registered output stage
  lsc_fifo #(
    .W (lsc_pkg::FIFO_WIDTH),
    .D (lsc_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clk       (CLK),
    .rst_n     (RST_N),
    .in_valid  (state == lsc_pkg::ST_RESP),
    .in_ready  (push_ok_raw),
    .in_data   (push_data),
    .out_valid (fifo_valid),
    .out_ready (fifo_take),
    .out_data  (fifo_data)
  );
  assign push_ok = push_ok_raw && state == lsc_pkg::ST_RESP;

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      TX_VALID <= 1'b0;
      TX_DATA  <= 8'h00;
    end else if (fifo_take) begin
      TX_VALID <= fifo_valid;
      TX_DATA  <= fifo_data;
    end
  end

  // Operation strobes, one cycle each
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      {SEND_FLUSH, SEND_MARK, GET_HEADER, GET_PAYLOAD, GET_WHOLE, DROP_RX_PACKET,
       DROP_RX_ALL, FLUSH_OUTBOUND, FLUSH_INBOUND, JOIN_HALT, JOIN_START,
       KEY_RCV_CLEAR, NV_DEFAULTS, SELF_RESET} <= '0;
    end else begin
      {SEND_FLUSH, SEND_MARK, GET_HEADER, GET_PAYLOAD, GET_WHOLE, DROP_RX_PACKET,
       DROP_RX_ALL, FLUSH_OUTBOUND, FLUSH_INBOUND, JOIN_HALT, JOIN_START,
       KEY_RCV_CLEAR, NV_DEFAULTS} <= '0;
      SELF_RESET <= resp_msg && push_ok && resp_idx == resp_len - 5'd1;
      if (state == lsc_pkg::ST_EXEC && wr_frame && !refused) begin
        case (op)
          lsc_pkg::OP_SEND: begin
            SEND_FLUSH <= !EXPLICIT_TX_PACKET_MODE;
            SEND_MARK  <= EXPLICIT_TX_PACKET_MODE;
          end
          lsc_pkg::OP_GET_HDR: GET_HEADER <= RECEIVED_PACKET_MODE && !retr_busy;
          lsc_pkg::OP_GET_PAY: GET_PAYLOAD <= RECEIVED_PACKET_MODE && !retr_busy;
          lsc_pkg::OP_GET_ALL: GET_WHOLE <= RECEIVED_PACKET_MODE && !retr_busy;
          lsc_pkg::OP_DROP_RX: begin
            DROP_RX_PACKET <= RECEIVED_PACKET_MODE;
            DROP_RX_ALL    <= !RECEIVED_PACKET_MODE;
          end
          lsc_pkg::OP_FLUSH_OB: FLUSH_OUTBOUND <= 1'b1;
          lsc_pkg::OP_FLUSH_IB: FLUSH_INBOUND <= 1'b1;
          lsc_pkg::OP_JOIN: begin
            JOIN_HALT     <= arg == lsc_pkg::JOIN_STOP;
            JOIN_START    <= arg == lsc_pkg::JOIN_ADMIN || arg == lsc_pkg::JOIN_NODE;
            KEY_RCV_CLEAR <= arg == lsc_pkg::JOIN_ADMIN;
          end
          lsc_pkg::OP_FACTORY: begin
            NV_DEFAULTS <= arg == lsc_pkg::FACT_KEY1 && body[3] == lsc_pkg::FACT_KEY2;
          end
          default: ;
        endcase
      end
    end
  end

  // Retrieval in progress until transfer done or packet dropped
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      retr_busy <= 1'b0;
    end else if (GET_HEADER || GET_PAYLOAD || GET_WHOLE) begin
      retr_busy <= 1'b1;
    end else if (RX_XFER_DONE || DROP_RX_PACKET) begin
      retr_busy <= 1'b0;
    end
  end

  // Join tracking, role and push-button gating
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      JOIN_ACTIVE   <= 1'b0;
      JOIN_AS_ADMIN <= 1'b0;
      COPY_NV_ADDR  <= 1'b0;
      PB_JOIN_GO    <= 1'b0;
    end else begin
      COPY_NV_ADDR <= JOIN_ACTIVE && JOIN_DONE && JOIN_OK;
      PB_JOIN_GO   <= PB_JOIN_REQ && !JOIN_ACTIVE && !JOIN_START;
      if (JOIN_HALT || JOIN_DONE) begin
        JOIN_ACTIVE <= 1'b0;
      end else if (JOIN_START || PB_JOIN_GO) begin
        JOIN_ACTIVE   <= 1'b1;
        JOIN_AS_ADMIN <= KEY_RCV_CLEAR || !KEY_RECEIVE_PERMIT;
      end
    end
  end

  // Receive-waiting flag follows undelivered bytes, cleared by flush
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      RECEIVE_WAITING_FLAG <= 1'b0;
    end else begin
      RECEIVE_WAITING_FLAG <= RX_UNDELIVERED && !FLUSH_INBOUND;
    end
  end

  // Runtime key: write, erase, restore, power-up load from stored key
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      load_pend <= 1'b1;
      for (int i = 0; i < lsc_pkg::KEY_BYTES; i++) runtime_key[i] <= 8'h00;
    end else begin
      load_pend <= 1'b0;
      for (int i = 0; i < lsc_pkg::KEY_BYTES; i++) begin
        if (load_pend) begin
          runtime_key[i] <= stored_key[i];
        end else if (state == lsc_pkg::ST_EXEC && wr_frame && !refused) begin
          if (op == lsc_pkg::OP_KEY_WR && arg == lsc_pkg::SEL_RUNTIME) begin
            runtime_key[i] <= body[3+i];
          end else if (op == lsc_pkg::OP_KEY_ERA && arg == lsc_pkg::SEL_RUNTIME) begin
            runtime_key[i] <= 8'h00;
          end else if (op == lsc_pkg::OP_KEY_RST) begin
            runtime_key[i] <= stored_key[i];
          end
        end
      end
    end
  end

  // Stored key models non-volatile contents; defaults to zero
  always_ff @(posedge CLK) begin
    for (int i = 0; i < lsc_pkg::KEY_BYTES; i++) begin
      if (!RST_N && load_pend) begin
        stored_key[i] <= 8'h00;
      end else if (NV_DEFAULTS) begin
        stored_key[i] <= 8'h00;
      end else if (state == lsc_pkg::ST_EXEC && wr_frame && !refused
                   && arg == lsc_pkg::SEL_STORED) begin
        if (op == lsc_pkg::OP_KEY_WR) stored_key[i] <= body[3+i];
        else if (op == lsc_pkg::OP_KEY_ERA) stored_key[i] <= 8'h00;
      end
    end
  end

  // Key presence and flattened runtime key
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      RUNTIME_KEY_PRESENT <= 1'b0;
      STORED_KEY_PRESENT  <= 1'b0;
      RUNTIME_KEY         <= '0;
    end else begin
      RUNTIME_KEY_PRESENT <= key_nonzero(runtime_key);
      STORED_KEY_PRESENT  <= key_nonzero(stored_key);
      for (int i = 0; i < lsc_pkg::KEY_BYTES; i++) RUNTIME_KEY[8*i +: 8] <= runtime_key[i];
    end
  end

  // Checks
  status_mirror_a: assert property (@(posedge CLK) disable iff (!RST_N)
    ##1 output_line_status[5:0] == $past({UART_BUFFER_EMPTY, RF_ACTIVITY_INDICATOR,
      INBOUND_NEAR_FULL, RECEIVE_AMP_ON, TRANSMIT_AMP_ON, FAULT_EVENT_LINE}))
    else $error("status byte does not mirror lines");
  status_resv_a: assert property (@(posedge CLK) disable iff (!RST_N)
    output_line_status[7:6] == 2'b00) else $error("reserved status bits set");
  send_mode_a: assert property (@(posedge CLK) disable iff (!RST_N)
    (SEND_FLUSH |-> !$past(EXPLICIT_TX_PACKET_MODE)) and
    (SEND_MARK |-> $past(EXPLICIT_TX_PACKET_MODE))) else $error("send mode wrong");
  get_gate_a: assert property (@(posedge CLK) disable iff (!RST_N)
    (GET_HEADER || GET_PAYLOAD || GET_WHOLE)
      |-> $past(RECEIVED_PACKET_MODE) && !$past(retr_busy))
    else $error("retrieval issued while refused");
  get_busy_a: assert property (@(posedge CLK) disable iff (!RST_N)
    GET_HEADER |=> retr_busy) else $error("retrieval not tracked");
  join_refuse_a: assert property (@(posedge CLK) disable iff (!RST_N)
    (FLUSH_OUTBOUND || FLUSH_INBOUND || SEND_FLUSH || SEND_MARK || JOIN_START)
      |-> !$past(JOIN_ACTIVE)) else $error("write accepted during join");
  pb_ignore_a: assert property (@(posedge CLK) disable iff (!RST_N)
    PB_JOIN_GO |-> !$past(JOIN_ACTIVE)) else $error("button join not ignored");
  flush_in_a: assert property (@(posedge CLK) disable iff (!RST_N)
    FLUSH_INBOUND |=> !RECEIVE_WAITING_FLAG) else $error("wait flag not cleared");
  copy_addr_a: assert property (@(posedge CLK) disable iff (!RST_N)
    COPY_NV_ADDR |-> $past(JOIN_DONE && JOIN_OK)) else $error("bad address copy");
  halt_ack_a: assert property (@(posedge CLK) disable iff (!RST_N)
    JOIN_HALT |=> !JOIN_ACTIVE) else $error("halt did not end join");
  cov_status_c: cover property (@(posedge CLK) disable iff (!RST_N)
    state == lsc_pkg::ST_EXEC && is_read);
  cov_get_c: cover property (@(posedge CLK) disable iff (!RST_N) GET_WHOLE);
  cov_reset_c: cover property (@(posedge CLK) disable iff (!RST_N) SELF_RESET);
endmodule

// File: testbench/line_status_and_command_unit_tb.sv
// Self-checking bench for the line status and command unit
`timescale 1ns/100ps
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin mismatches++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (a), (b)); end end
module line_status_and_command_unit_tb;
  logic         CLK = 0, RST_N = 0, RX_VALID = 0, clr = 0;
  logic [7:0]   RX_DATA = 8'h00, rnd = 8'h34;
  logic [5:0]   ind = 6'h00;
  logic         txm = 0, rxm = 0, krp = 0, xd = 0, und = 0, jd = 0, jok = 0, pb = 0;
  logic [15:0]  stb, seen = 16'h0000;
  logic         RX_READY, TX_VALID, TX_READY, ja, jadm, rwf, rkp, skp;
  logic [7:0]   TX_DATA, ops[7] = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07};
  logic [127:0] rk, key;
  logic [7:0]   kq[$];
  int           bits[7] = '{15, 13, 12, 11, 10, 8, 7};
  int           mismatches = 0, tests_run = 0, cyc = 0;
  always #10 CLK = ~CLK;
  lsc_top dut (.CLK(CLK), .RST_N(RST_N), .RX_VALID(RX_VALID), .RX_DATA(RX_DATA),
    .RX_READY(RX_READY), .TX_VALID(TX_VALID), .TX_DATA(TX_DATA), .TX_READY(TX_READY),
    .FAULT_EVENT_LINE(ind[0]), .TRANSMIT_AMP_ON(ind[1]), .RECEIVE_AMP_ON(ind[2]),
    .INBOUND_NEAR_FULL(ind[3]), .RF_ACTIVITY_INDICATOR(ind[4]), .UART_BUFFER_EMPTY(ind[5]),
    .EXPLICIT_TX_PACKET_MODE(txm), .RECEIVED_PACKET_MODE(rxm), .KEY_RECEIVE_PERMIT(krp),
    .RX_XFER_DONE(xd), .RX_UNDELIVERED(und), .JOIN_DONE(jd), .JOIN_OK(jok), .PB_JOIN_REQ(pb),
    .SEND_FLUSH(stb[15]), .SEND_MARK(stb[14]), .GET_HEADER(stb[13]), .GET_PAYLOAD(stb[12]),
    .GET_WHOLE(stb[11]), .DROP_RX_PACKET(stb[10]), .DROP_RX_ALL(stb[9]),
    .FLUSH_OUTBOUND(stb[8]), .FLUSH_INBOUND(stb[7]), .JOIN_HALT(stb[6]), .JOIN_START(stb[5]),
    .KEY_RCV_CLEAR(stb[4]), .COPY_NV_ADDR(stb[3]), .PB_JOIN_GO(stb[2]),
    .NV_DEFAULTS(stb[1]), .SELF_RESET(stb[0]), .JOIN_ACTIVE(ja), .JOIN_AS_ADMIN(jadm),
    .RECEIVE_WAITING_FLAG(rwf), .RUNTIME_KEY_PRESENT(rkp), .STORED_KEY_PRESENT(skp),
    .RUNTIME_KEY(rk));
  lsc_host_model host (.CLK(CLK), .TX_VALID(TX_VALID), .TX_DATA(TX_DATA), .TX_READY(TX_READY));
  // Sticky record of strobes since the last frame was sent
  always @(posedge CLK) seen <= clr ? 16'h0000 : (seen | stb);
  // Hang guard
  always @(posedge CLK) begin
    cyc++;
    if (cyc == 20000) begin
      mismatches++;
      complete_run();
    end
  end
  function automatic logic [7:0] lf(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  // Status byte expected from the indicator levels
  function automatic logic [7:0] st_exp(input logic [5:0] l);
    return {2'b00, l};
  endfunction
  // Offer one byte and hold it until taken
  task automatic sb(input logic [7:0] b);
    @(negedge CLK);
    RX_VALID = 1'b1;
    RX_DATA = b;
    while (RX_READY !== 1'b1) @(negedge CLK);
    @(posedge CLK);
  endtask
  // Send a whole frame and wait for n answer bytes
  task automatic frame(input logic [7:0] b[$], input int n);
    int w;
    w = 0;
    host.q.delete();
    clr = 1'b1;
    sb(8'hff);
    sb(8'(b.size()));
    foreach (b[i]) sb(b[i]);
    @(negedge CLK);
    RX_VALID = 1'b0;
    clr = 1'b0;
    while (host.q.size() < n && w < 300) begin
      @(negedge CLK);
      w++;
    end
    if (w == 300) mismatches++;
    repeat (3) @(negedge CLK);
  endtask
  task automatic pulse_xd;
    @(negedge CLK) xd = 1'b1;
    @(negedge CLK) xd = 1'b0;
  endtask
  task automatic complete_run;
    $display("mismatches=%0d tests_run=%0d", mismatches, tests_run);
    if (mismatches == 0 && tests_run > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // Main sequence
  initial begin
    repeat (3) @(negedge CLK);
    RST_N = 1'b1;
    repeat (3) begin
      rnd = lf(rnd);
      ind = rnd[5:0];
      frame('{8'hfe, 8'hfe, 8'h46}, 3);
      `CHK(host.q[0], lsc_pkg::ACK_BYTE)
      `CHK(host.q[1], lsc_pkg::ADDR_STATUS)
      `CHK(host.q[2], st_exp(ind))
    end
    rxm = 1'b1;
    foreach (ops[i]) begin
      frame('{8'hfe, 8'h47, ops[i]}, 1);
      `CHK(host.q[0], lsc_pkg::ACK_BYTE)
      `CHK(seen, 16'h0001 << bits[i])
      pulse_xd();
    end
    frame('{8'hfe, 8'h47, 8'h02}, 1);
    frame('{8'hfe, 8'h47, 8'h03}, 1);
    `CHK(host.q[0], lsc_pkg::NACK_BYTE)
    pulse_xd();
    rxm = 1'b0;
    frame('{8'hfe, 8'h47, 8'h04}, 1);
    `CHK(host.q[0], lsc_pkg::NACK_BYTE)
    frame('{8'hfe, 8'h47, 8'h05}, 1);
    `CHK(seen, 16'h0200)
    txm = 1'b1;
    frame('{8'hfe, 8'h47, 8'h01}, 1);
    `CHK(seen, 16'h4000)
    und = 1'b1;
    repeat (2) @(negedge CLK);
    `CHK(rwf, 1'b1)
    und = 1'b0;
    repeat (2) @(negedge CLK);
    `CHK(rwf, 1'b0)
    frame('{8'hfe, 8'h47, 8'h10, 8'h02}, 1);
    `CHK({ja, seen}, 17'h10020)
    @(negedge CLK) pb = 1'b1;
    @(negedge CLK) pb = 1'b0;
    @(negedge CLK);
    `CHK(seen[2], 1'b0)
    frame('{8'hfe, 8'h47, 8'h06}, 1);
    `CHK(host.q[0], lsc_pkg::NACK_BYTE)
    frame('{8'hfe, 8'h47, 8'h10, 8'h00}, 1);
    `CHK({ja, host.q[0], seen}, {1'b0, lsc_pkg::ACK_BYTE, 16'h0040})
    krp = 1'b1;
    frame('{8'hfe, 8'h47, 8'h10, 8'h01}, 1);
    `CHK({jadm, seen}, 17'h10030)
    @(negedge CLK) {jd, jok} = 2'b11;
    @(negedge CLK) {jd, jok} = 2'b00;
    repeat (2) @(negedge CLK);
    `CHK({ja, seen[3]}, 2'b01)
    // Node role when key receive is permitted, then halt
    frame('{8'hfe, 8'h47, 8'h10, 8'h02}, 1);
    `CHK({ja, jadm}, 2'b10)
    frame('{8'hfe, 8'h47, 8'h10, 8'h00}, 1);
    kq = '{8'hfe, 8'h47, 8'h11, 8'h01};
    for (int i = 0; i < 16; i++) begin
      rnd = lf(rnd);
      key[8*i +: 8] = {1'b0, rnd[6:0] | 7'h01};
      kq.push_back(key[8*i +: 8]);
    end
    frame(kq, 1);
    `CHK({rkp, rk}, {1'b1, key})
    frame('{8'hfe, 8'h47, 8'h12, 8'h01}, 1);
    `CHK({rkp, rk}, 129'h0)
    kq[3] = 8'h02;
    frame(kq, 1);
    frame('{8'hfe, 8'h47, 8'h13}, 1);
    `CHK({skp, rkp, rk}, {2'b11, key})
    // Factory frame: text answer, defaults restored, self reset
    frame('{8'hfe, 8'h47, 8'h20, 8'hfe, 8'h2a, 8'hfe, 8'h3b}, 23);
    for (int i = 0; i < 23; i++) `CHK(host.q[i], lsc_pkg::RESET_MSG[8*(22-i) +: 8])
    `CHK({skp, seen}, 17'h00003)
    complete_run();
  end
endmodule

// File: testbench/lsc_host_model.sv
// Host-side answer sink with a random stall pattern
`timescale 1ns/100ps
module lsc_host_model (
  // Answer bus
  input  wire logic       CLK,
  input  wire logic       TX_VALID,
  input  wire logic [7:0] TX_DATA,
  output logic            TX_READY
);
  logic [7:0] q[$];
  logic [7:0] st = 8'h34;
  initial TX_READY = 1'b0;
  // Stall now and then, changed off the sampling edge
  always @(negedge CLK) begin
    st = {st[6:0], st[7] ^ st[5] ^ st[4] ^ st[3]};
    TX_READY <= st[0] | st[1];
  end
  // Take answer bytes in arrival order
  always @(posedge CLK) begin
    if (TX_VALID && TX_READY) q.push_back(TX_DATA);
  end
endmodule
